// [usb_dev_event_pkg.sv]
// Shared register map, field layout and reset values for the device event block
package usb_dev_event_pkg;

  localparam int unsigned NUM_ENGINES = 2;
  localparam int unsigned NUM_EPS     = 8;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned DATA_W      = 16;

  // Register offsets, engine one first
  localparam logic [15:0] ENABLES_OFS [NUM_ENGINES] = '{16'hC08C, 16'hC0AC};
  localparam logic [15:0] ADDR_OFS    [NUM_ENGINES] = '{16'hC08E, 16'hC0AE};
  localparam logic [15:0] FLAGS_OFS   [NUM_ENGINES] = '{16'hC090, 16'hC0B0};

  // Field positions shared by the enable and flag registers
  localparam int unsigned VBUS_BIT   = 15;
  localparam int unsigned ID_BIT     = 14;
  localparam int unsigned SOF_BIT    = 9;
  localparam int unsigned BUSRST_BIT = 8;
  localparam int unsigned EP_LSB     = 0;

  // Implemented bits; engine two has no VBUS or ID event
  localparam logic [15:0] BIT_MASK [NUM_ENGINES] = '{16'hC3FF, 16'h03FF};

  // Reset values
  localparam logic [15:0]       ENABLES_RST = 16'h0000;
  localparam logic [15:0]       FLAGS_RST   = 16'h0000;
  localparam logic [ADDR_W-1:0] DEV_ADDR_RST = 7'h00;
  localparam logic [15:0]       RDATA_RST   = 16'h0000;

  // Depth of the pin edge arming chain
  localparam int unsigned ARM_DEPTH = 3;

endpackage

// [usb_pin_edge_sync.sv]
// Two-flop pin synchroniser with a both-edge event pulse
module usb_pin_edge_sync
  import usb_dev_event_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_edge
);

  logic                 meta_q, meta_d;
  logic                 sync_q, sync_d;
  logic                 prev_q, prev_d;
  logic [ARM_DEPTH-1:0] arm_q, arm_d;

  // The first flop feeds only the second; the edge compares the second and third
  always_comb begin
    meta_d = i_pin;
    sync_d = meta_q;
    prev_d = sync_q;
    arm_d  = {arm_q[ARM_DEPTH-2:0], 1'b1};
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      arm_q  <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
      arm_q  <= arm_d;
    end
  end

  // Edges are held off until the chain has filled, else a pin high at reset looks like a rise
  assign o_level = sync_q;
  assign o_edge  = arm_q[ARM_DEPTH-1] & (sync_q ^ prev_q);

endmodule

// [usb_device_event_and_address.sv]
// Device event enables, event flags and address match for two USB engines
//
// Behaviour
// - Eight endpoint enables gate transaction-done events
// - ACK, STALL, timeout, IN/OUT error fire event
// - NAK fires event when endpoint NAK enabled
// - Write-only seven-bit address at fixed offsets
// - Address resets to zero default
// - Respond only to packets matching stored address
// - Writing one clears flag, zero leaves it
// - Flags reachable from processor and host port
// - Engine one bit 15: VBUS crossing event
// - Engine one bit 14: ID pin edge
// - Bit 9 set on SOF/EOP received
// - Bit 8 set on USB bus reset
// - Enables at bits 15,14,9,8; reset zero
// - Enable register at fixed offsets per engine
//
// Limitations: the SOF timeout enable at bit 11 is not kept and reads 0,
// and when both ports write one control register in a cycle the processor wins
module usb_device_event_and_address
  import usb_dev_event_pkg::*;
(
  // Clock and asynchronous reset
  input  wire logic                            i_mclk,
  input  wire logic                            i_arst_n,
  // On-chip processor register port
  input  wire logic [15:0]                     i_cpu_addr,
  input  wire logic                            i_cpu_wr,
  input  wire logic                            i_cpu_rd,
  input  wire logic [DATA_W-1:0]               i_cpu_wdata,
  output logic      [DATA_W-1:0]               o_cpu_rdata,
  // Parallel host port register access
  input  wire logic [15:0]                     i_parallel_host_port_addr,
  input  wire logic                            i_parallel_host_port_wr,
  input  wire logic                            i_parallel_host_port_rd,
  input  wire logic [DATA_W-1:0]               i_parallel_host_port_wdata,
  output logic      [DATA_W-1:0]               o_parallel_host_port_rdata,
  // Per-engine endpoint results, one bit per endpoint, engine one in the low byte
  input  wire logic [NUM_ENGINES*NUM_EPS-1:0]  i_endpoint_n_ack,
  input  wire logic [NUM_ENGINES*NUM_EPS-1:0]  i_endpoint_n_stall,
  input  wire logic [NUM_ENGINES*NUM_EPS-1:0]  i_endpoint_n_timeout,
  input  wire logic [NUM_ENGINES*NUM_EPS-1:0]  i_endpoint_n_in_err,
  input  wire logic [NUM_ENGINES*NUM_EPS-1:0]  i_endpoint_n_out_err,
  input  wire logic [NUM_ENGINES*NUM_EPS-1:0]  i_endpoint_n_nak,
  input  wire logic [NUM_ENGINES*NUM_EPS-1:0]  i_endpoint_n_nak_en,
  // Per-engine frame and bus reset events
  input  wire logic [NUM_ENGINES-1:0]          i_sof_rx,
  input  wire logic [NUM_ENGINES-1:0]          i_bus_reset,
  // Per-engine token address check
  input  wire logic [NUM_ENGINES-1:0]          i_tok_valid,
  input  wire logic [NUM_ENGINES*ADDR_W-1:0]   i_tok_addr,
  output logic      [NUM_ENGINES-1:0]          o_tok_accept,
  // First port OTG pins, asynchronous
  input  wire logic                            i_first_port_a_vbus_ok,
  input  wire logic                            i_first_port_a_id,
  output logic                                 o_first_port_a_id_level,
  // Current device addresses and interrupt requests
  output logic      [NUM_ENGINES*ADDR_W-1:0]   o_dev_addr,
  output logic      [NUM_ENGINES-1:0]          o_irq
);

  // Pin events and per-engine register views for the read mux
  logic                            vbus_edge;
  logic                            id_edge;
  logic [NUM_ENGINES-1:0][15:0]    en_all;
  logic [NUM_ENGINES-1:0][15:0]    flags_all;
  logic [DATA_W-1:0]               cpu_rdata_q, cpu_rdata_d;
  logic [DATA_W-1:0]               php_rdata_q, php_rdata_d;

  // OTG pins cross into the clock domain before any event logic sees them
  usb_pin_edge_sync u_vbus_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_pin    (i_first_port_a_vbus_ok),
    .o_level  (),
    .o_edge   (vbus_edge)
  );

  // The ID level is also brought out so firmware can see the current role
  usb_pin_edge_sync u_id_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_pin    (i_first_port_a_id),
    .o_level  (o_first_port_a_id_level),
    .o_edge   (id_edge)
  );

  // One copy per engine; engine two has the pin events masked off,
  // so its bits 15 and 14 always read 0
  for (genvar e = 0; e < NUM_ENGINES; e++) begin : g_eng
    logic [15:0]       en_q, en_d;
    logic [15:0]       flags_q, flags_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic              irq_q, irq_d;
    logic [15:0]       events;
    logic [15:0]       clr;
    logic [NUM_EPS-1:0] ep_evt;
    // Write strobes decoded per register and per port
    logic              cpu_en_wr, php_en_wr;
    logic              cpu_addr_wr, php_addr_wr;
    logic              cpu_flag_wr, php_flag_wr;

    // Register decode for both access ports
    assign cpu_en_wr   = i_cpu_wr && (i_cpu_addr == ENABLES_OFS[e]);
    assign php_en_wr   = i_parallel_host_port_wr
                         && (i_parallel_host_port_addr == ENABLES_OFS[e]);
    assign cpu_addr_wr = i_cpu_wr && (i_cpu_addr == ADDR_OFS[e]);
    assign php_addr_wr = i_parallel_host_port_wr
                         && (i_parallel_host_port_addr == ADDR_OFS[e]);
    assign cpu_flag_wr = i_cpu_wr && (i_cpu_addr == FLAGS_OFS[e]);
    assign php_flag_wr = i_parallel_host_port_wr
                         && (i_parallel_host_port_addr == FLAGS_OFS[e]);

    // Transaction done per endpoint; NAK only counts when its endpoint asks for it
    assign ep_evt = i_endpoint_n_ack[e*NUM_EPS +: NUM_EPS]
                  | i_endpoint_n_stall[e*NUM_EPS +: NUM_EPS]
                  | i_endpoint_n_timeout[e*NUM_EPS +: NUM_EPS]
                  | i_endpoint_n_in_err[e*NUM_EPS +: NUM_EPS]
                  | i_endpoint_n_out_err[e*NUM_EPS +: NUM_EPS]
                  | (i_endpoint_n_nak[e*NUM_EPS +: NUM_EPS]
                     & i_endpoint_n_nak_en[e*NUM_EPS +: NUM_EPS]);

    // Raw events in flag layout; OTG pins exist on engine one only
    always_comb begin
      events                         = 16'h0000;
      events[EP_LSB +: NUM_EPS]      = ep_evt;
      events[SOF_BIT]                = i_sof_rx[e];
      events[BUSRST_BIT]             = i_bus_reset[e];
      if (e == 0) begin
        events[VBUS_BIT]             = vbus_edge;
        events[ID_BIT]               = id_edge;
      end
    end

    // Clear mask is the OR of both ports so neither port's clear is lost
    assign clr = (cpu_flag_wr ? i_cpu_wdata : 16'h0000)
               | (php_flag_wr ? i_parallel_host_port_wdata : 16'h0000);

    // Next state; processor wins if both ports write a control register together
    always_comb begin
      en_d = en_q;
      if (cpu_en_wr) begin
        en_d = i_cpu_wdata & BIT_MASK[e];
      end else if (php_en_wr) begin
        en_d = i_parallel_host_port_wdata & BIT_MASK[e];
      end
      addr_d = addr_q;
      if (cpu_addr_wr) begin
        addr_d = i_cpu_wdata[ADDR_W-1:0];
      end else if (php_addr_wr) begin
        addr_d = i_parallel_host_port_wdata[ADDR_W-1:0];
      end
      // A set arriving with its own clear wins, so no event is dropped
      flags_d = ((flags_q & ~clr) | (events & en_q)) & BIT_MASK[e];
      irq_d   = |(flags_q & en_q);
    end

    // Registers only; all next values come from the block above
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        en_q    <= ENABLES_RST;
        addr_q  <= DEV_ADDR_RST;
        flags_q <= FLAGS_RST;
        irq_q   <= 1'b0;
      end else begin
        en_q    <= en_d;
        addr_q  <= addr_d;
        flags_q <= flags_d;
        irq_q   <= irq_d;
      end
    end

    // Packets for any other address are dropped without a reply
    assign o_tok_accept[e] = i_tok_valid[e]
                             && (i_tok_addr[e*ADDR_W +: ADDR_W] == addr_q);
    assign o_dev_addr[e*ADDR_W +: ADDR_W] = addr_q;
    assign o_irq[e]     = irq_q;
    assign en_all[e]    = en_q;
    assign flags_all[e] = flags_q;
  end

  // Read mux; the address register is write-only and reads as zero like any hole
  always_comb begin
    cpu_rdata_d = cpu_rdata_q;
    php_rdata_d = php_rdata_q;
    if (i_cpu_rd) begin
      cpu_rdata_d = RDATA_RST;
      for (int k = 0; k < NUM_ENGINES; k++) begin
        if (i_cpu_addr == ENABLES_OFS[k]) begin
          cpu_rdata_d = en_all[k];
        end
        if (i_cpu_addr == FLAGS_OFS[k]) begin
          cpu_rdata_d = flags_all[k];
        end
      end
    end
    if (i_parallel_host_port_rd) begin
      php_rdata_d = RDATA_RST;
      for (int k = 0; k < NUM_ENGINES; k++) begin
        if (i_parallel_host_port_addr == ENABLES_OFS[k]) begin
          php_rdata_d = en_all[k];
        end
        if (i_parallel_host_port_addr == FLAGS_OFS[k]) begin
          php_rdata_d = flags_all[k];
        end
      end
    end
  end

  // Read data held until the next read on the same port
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cpu_rdata_q <= RDATA_RST;
      php_rdata_q <= RDATA_RST;
    end else begin
      cpu_rdata_q <= cpu_rdata_d;
      php_rdata_q <= php_rdata_d;
    end
  end

  // Read data leave straight from flops, so no decode glitch reaches the pins
  assign o_cpu_rdata                = cpu_rdata_q;
  assign o_parallel_host_port_rdata = php_rdata_q;

endmodule

// [usb_device_event_and_address_monitor.sv]
// Port checker for the device event and address block
module usb_device_event_and_address_monitor
  import usb_dev_event_pkg::*;
(
  input wire logic                        i_mclk,
  input wire logic                        i_arst_n,
  input wire logic [15:0]                 i_cpu_addr,
  input wire logic                        i_cpu_wr,
  input wire logic                        i_cpu_rd,
  input wire logic [DATA_W-1:0]           i_cpu_wdata,
  input wire logic [DATA_W-1:0]           o_cpu_rdata,
  input wire logic [15:0]                 i_parallel_host_port_addr,
  input wire logic                        i_parallel_host_port_wr,
  input wire logic                        i_parallel_host_port_rd,
  input wire logic [DATA_W-1:0]           i_parallel_host_port_wdata,
  input wire logic [DATA_W-1:0]           o_parallel_host_port_rdata,
  input wire logic [NUM_ENGINES-1:0]      i_tok_valid,
  input wire logic [NUM_ENGINES*ADDR_W-1:0] i_tok_addr,
  input wire logic [NUM_ENGINES-1:0]      o_tok_accept,
  input wire logic [NUM_ENGINES*ADDR_W-1:0] o_dev_addr,
  input wire logic [NUM_ENGINES-1:0]      o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic w_en1;
  logic w_any1;
  // Writes that can change what drives the engine-two interrupt
  assign w_en1 = (i_cpu_wr && i_cpu_addr == ENABLES_OFS[1])
    || (i_parallel_host_port_wr && i_parallel_host_port_addr == ENABLES_OFS[1]);
  assign w_any1 = w_en1 || (i_cpu_wr && i_cpu_addr == FLAGS_OFS[1])
    || (i_parallel_host_port_wr && i_parallel_host_port_addr == FLAGS_OFS[1]);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  sequence s_quiet;
    !w_any1 ##1 o_irq[1];
  endsequence
  sequence s_en_wr_rd;
    i_cpu_wr && i_cpu_addr == ENABLES_OFS[1] ##1 !w_en1
      ##1 i_cpu_rd && i_cpu_addr == ENABLES_OFS[1];
  endsequence
  property p_tok;
    o_tok_accept == {i_tok_valid[1] && i_tok_addr[13:7] == o_dev_addr[13:7],
                     i_tok_valid[0] && i_tok_addr[6:0] == o_dev_addr[6:0]};
  endproperty
  property p_rst;
    $rose(i_arst_n) |-> o_dev_addr == '0 && o_irq == '0;
  endproperty
  property p_addr0;
    i_cpu_wr && i_cpu_addr == ADDR_OFS[0] |=>
      {9'h000, o_dev_addr[6:0]} == ($past(i_cpu_wdata) & 16'h007F);
  endproperty
  property p_addr1;
    i_parallel_host_port_wr && i_parallel_host_port_addr == ADDR_OFS[1]
      && !(i_cpu_wr && i_cpu_addr == ADDR_OFS[1]) |=>
      {9'h000, o_dev_addr[13:7]} == ($past(i_parallel_host_port_wdata) & 16'h007F);
  endproperty
  property p_wo;
    i_cpu_rd && (i_cpu_addr == ADDR_OFS[0] || i_cpu_addr == ADDR_OFS[1])
      |=> o_cpu_rdata == 16'h0000;
  endproperty
  property p_rsvd2;
    i_parallel_host_port_rd && i_parallel_host_port_addr == FLAGS_OFS[1] |=>
      (o_parallel_host_port_rdata & ~BIT_MASK[1]) == 16'h0000;
  endproperty
  property p_hold;
    s_quiet |=> o_irq[1];
  endproperty
  property p_enrb;
    s_en_wr_rd |=> o_cpu_rdata == ($past(i_cpu_wdata, 3) & BIT_MASK[1]);
  endproperty
  a_tok: assert property (p_tok) else $error("token accept wrong");
  a_rst: assert property (p_rst) else $error("address or irq not zero after reset");
  a_addr0: assert property (p_addr0) else $error("engine one address not stored");
  a_addr1: assert property (p_addr1) else $error("host port address not stored");
  a_wo: assert property (p_wo) else $error("address register readable");
  a_rsvd2: assert property (p_rsvd2) else $error("engine two pin flag bits set");
  a_hold: assert property (p_hold) else $error("irq dropped without a clear");
  a_enrb: assert property (p_enrb) else $error("enable readback wrong");
endmodule

bind usb_device_event_and_address usb_device_event_and_address_monitor u_mon (
  .i_mclk, .i_arst_n, .i_cpu_addr, .i_cpu_wr, .i_cpu_rd, .i_cpu_wdata, .o_cpu_rdata,
  .i_parallel_host_port_addr, .i_parallel_host_port_wr, .i_parallel_host_port_rd,
  .i_parallel_host_port_wdata, .o_parallel_host_port_rdata,
  .i_tok_valid, .i_tok_addr, .o_tok_accept, .o_dev_addr, .o_irq);

// [usb_host_model.sv]
// Behavioural USB host presenting token addresses to both engines
module usb_host_model (
  input  wire logic        i_mclk,
  input  wire logic [1:0]  i_req,
  input  wire logic [13:0] i_addr,
  input  wire logic [3:0]  i_slow,
  output logic      [1:0]  o_tok_valid,
  output logic      [13:0] o_tok_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // One token per request after i_slow idle cycles; between tokens the
  // address lines flip every cycle while no request is pending, so a stale address never looks valid
  initial begin
    o_tok_valid = 2'h0;
    o_tok_addr  = 14'h0000;
    forever begin
      @(negedge i_mclk);
      if (i_req != 2'h0) begin
        repeat (i_slow) @(negedge i_mclk);
        o_tok_valid = i_req;
        o_tok_addr  = i_addr;
        @(negedge i_mclk);
      end
      o_tok_valid = 2'h0;
      o_tok_addr  = ~o_tok_addr;
    end
  end
endmodule

// [usb_device_event_and_address_tb.sv]
// Self-checking bench for the device event and address block
module usb_device_event_and_address_tb import usb_dev_event_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, arst_n, cw, cr, hw, hr, vb, id, idl, ne;
  logic [15:0] ca, cd, crd, ha, hd, hrd, rdv, nak_en, en, x;
  logic [15:0] ev [6];
  logic [15:0] ofs [7];
  logic [1:0]  sof, brst, req, tv, acc_o, irq;
  logic [13:0] raddr, ta, dev;
  logic [6:0]  ad [2];
  logic [3:0]  slow;
  int          err_total, compares, cyc, e, n, t;

  usb_device_event_and_address usb_device_event_and_address_inst (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_cpu_addr(ca), .i_cpu_wr(cw), .i_cpu_rd(cr),
    .i_cpu_wdata(cd), .o_cpu_rdata(crd), .i_parallel_host_port_addr(ha),
    .i_parallel_host_port_wr(hw), .i_parallel_host_port_rd(hr),
    .i_parallel_host_port_wdata(hd), .o_parallel_host_port_rdata(hrd),
    .i_endpoint_n_ack(ev[0]), .i_endpoint_n_stall(ev[1]), .i_endpoint_n_timeout(ev[2]),
    .i_endpoint_n_in_err(ev[3]), .i_endpoint_n_out_err(ev[4]), .i_endpoint_n_nak(ev[5]),
    .i_endpoint_n_nak_en(nak_en), .i_sof_rx(sof), .i_bus_reset(brst), .i_tok_valid(tv),
    .i_tok_addr(ta), .o_tok_accept(acc_o), .i_first_port_a_vbus_ok(vb),
    .i_first_port_a_id(id), .o_first_port_a_id_level(idl), .o_dev_addr(dev), .o_irq(irq));
  usb_host_model usb_host_model_inst (.i_mclk(mclk), .i_req(req), .i_addr(raddr),
    .i_slow(slow), .o_tok_valid(tv), .o_tok_addr(ta));

  // Free-running clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      results();
    end
  end

  // One register access; strobes last exactly one cycle
  task automatic acc(bit p, bit w, logic [15:0] a, logic [15:0] d);
    @(negedge mclk);
    if (p) {hw, hr, ha, hd} = {w, !w, a, d};
    else {cw, cr, ca, cd} = {w, !w, a, d};
    @(negedge mclk);
    {cw, cr, hw, hr} = 4'h0;
    rdv = p ? hrd : crd;
  endtask
  task automatic chk(logic [15:0] g, logic [15:0] xp);
    compares++;
    if (g !== xp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, xp);
    end
  endtask
  // Ask the host for a token and judge acceptance against the stored address
  task automatic tok(int eng, logic [6:0] a);
    @(posedge mclk);
    req[eng] = 1'b1;
    raddr[eng*7 +: 7] = a;
    for (int i = 0; i < 20 && !tv[eng]; i++) @(posedge mclk) #1;
    req = 2'h0;
    chk({14'h0, tv[eng], acc_o[eng]}, {14'h0, 1'b1, a == ad[eng]});
  endtask
  function automatic logic [15:0] fexp(int k, int b, logic [15:0] m, logic nk);
    logic [15:0] r;
    r = (k == 6) ? 16'h0200 : (k == 7) ? 16'h0100 : 16'h0001 << b;
    if (k == 5 && !nk) r = 16'h0000;
    return r & m;
  endfunction
  task automatic results();
    $display("Checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {arst_n, cw, cr, hw, hr, vb, id, ne} = 8'h02;
    {ca, cd, ha, hd, nak_en, en} = '0;
    foreach (ev[i]) ev[i] = 16'h0000;
    {sof, brst, req, raddr, slow} = '0;
    ad = '{7'h00, 7'h00};
    ofs = '{ENABLES_OFS[0], ADDR_OFS[0], FLAGS_OFS[0], ENABLES_OFS[1], ADDR_OFS[1],
            FLAGS_OFS[1], 16'hC092};
    void'($urandom(77023));
    repeat (12) @(negedge mclk);
    arst_n = 1'b1;
    // Reset contents, an unmapped place among them
    foreach (ofs[r]) begin
      acc(r % 2 == 1, 0, ofs[r], 16'h0000);
      chk(rdv, 16'h0000);
    end
    chk({irq, dev}, 16'h0000);
    tok(0, 7'h00);
    $display("reset test done");
    // Every event kind, endpoints zero and seven first, random enables
    for (int k = 0; k < 40; k++) begin
      e = $urandom % 2;
      n = (k < 2) ? k * 7 : $urandom % 8;
      t = (k < 8) ? k : $urandom % 8;
      ne = 1'($urandom);
      en = {6'h00, 2'($urandom), 8'($urandom)};
      nak_en[e*8 + n] = ne;
      acc(k[0], 1, ENABLES_OFS[e], en);
      acc(0, 0, ENABLES_OFS[e], 16'h0000);
      chk(rdv, en);
      x = fexp(t, n, en, ne);
      @(negedge mclk);
      if (t < 6) ev[t][e*8 + n] = 1'b1;
      else if (t == 6) sof[e] = 1'b1;
      else brst[e] = 1'b1;
      @(negedge mclk);
      foreach (ev[i]) ev[i] = 16'h0000;
      {sof, brst} = 4'h0;
      acc(1, 0, FLAGS_OFS[e], 16'h0000);
      chk(rdv, x);
      chk({15'h0, irq[e]}, {15'h0, x != 0});
      acc(0, 1, FLAGS_OFS[e], 16'h0000);
      acc(1, 0, FLAGS_OFS[e], 16'h0000);
      chk(rdv, x);
      acc(k[1], 1, FLAGS_OFS[e], x);
      acc(0, 0, FLAGS_OFS[e], 16'h0000);
      chk({irq[e], rdv[14:0]}, 16'h0000);
    end
    // Corner: an event beats a clear on the same edge, and both ports clear together
    acc(0, 1, ENABLES_OFS[0], 16'h0003);
    ev[0] = 16'h0002;
    @(negedge mclk);
    ev[0] = 16'h0001;
    {cw, ca, cd} = {1'b1, FLAGS_OFS[0], 16'h0001};
    {hw, ha, hd} = {1'b1, FLAGS_OFS[0], 16'h0002};
    @(negedge mclk);
    {cw, hw, ev[0]} = {2'b00, 16'h0000};
    acc(0, 0, FLAGS_OFS[0], 16'h0000);
    chk(rdv, 16'h0001);
    acc(1, 1, FLAGS_OFS[0], 16'h0001);
    acc(1, 0, FLAGS_OFS[0], 16'h0000);
    chk(rdv, 16'h0000);
    $display("event test done");
    // Both edges of both first-port pins
    acc(0, 1, ENABLES_OFS[0], 16'hC000);
    for (int j = 0; j < 4; j++) begin
      if (j % 2 == 1) id = ~id;
      else vb = ~vb;
      repeat (8) @(negedge mclk);
      acc(1, 0, FLAGS_OFS[0], 16'h0000);
      chk(rdv, (j % 2 == 1) ? 16'h4000 : 16'h8000);
      chk({15'h0, idl}, {15'h0, id});
      acc(0, 1, FLAGS_OFS[0], 16'hC000);
    end
    $display("pin test done");
    // Address from either port, matching and near-miss tokens, slow host
    for (int j = 0; j < 6; j++) begin
      e = j % 2;
      ad[e] = (j < 2) ? 7'h7F : 7'($urandom);
      slow = 4'(j);
      acc(j[1], 1, ADDR_OFS[e], {9'h000, ad[e]});
      chk({2'b00, dev}, {2'b00, ad[1], ad[0]});
      acc(j[0], 0, ADDR_OFS[e], 16'h0000);
      chk(rdv, 16'h0000);
      tok(e, ad[e]);
      tok(e, ad[e] ^ 7'h01);
    end
    $display("address test done");
    results();
  end
endmodule
